// >>> src/psc_strap_loader.v
// Strap sampling and decode for the transceiver's hardware-reset options.
`timescale 1ns/1ns
`include "psc_consts.vh"
module psc_strap_loader #(
    parameter RESET_HOLD_CYCLES = `PSC_RESET_HOLD_CYCLES
) (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        clkEn,
    input  wire        hw_reset_n,
    input  wire        power_down_pin_n,
    input  wire        softResetReq,
    input  wire        loopback_strap,
    input  wire        iface_mode_strap_a,
    input  wire        iface_mode_strap_b,
    input  wire        negotiation_enable_strap,
    input  wire        capability_strap_a,
    input  wire        capability_strap_b,
    input  wire        mgmt_addr_strap_bit0,
    input  wire        mgmt_addr_strap_bit1,
    input  wire        mgmt_addr_strap_bit2,
    input  wire        mgmt_addr_strap_bit3,
    input  wire        mgmt_addr_strap_bit4,
    input  wire [1:0]  signal_detect_neg,
    input  wire [1:0]  signal_detect_pos,
    input  wire [4:0]  mgmtFrameAddr,
    output reg         configLoaded,
    output reg         inHwReset,
    output reg  [1:0]  ifaceMode,
    output reg  [1:0]  mediaMode,
    output reg         negotiationEnable,
    output reg         forcedSpeed100,
    output reg         forcedFullDuplex,
    output reg  [3:0]  advertisedAbilities,
    output reg         loopbackEnable,
    output reg         isolate,
    output reg         powerDown,
    output reg         dataPathIsolated,
    output reg  [4:0]  mgmtAddr,
    output reg         mgmtAddrMatch,
    output reg  [15:0] controlSeed,
    output reg  [15:0] advertSeed,
    output reg  [15:0] rxModeSeed,
    output reg  [4:0]  rxModeIndex,
    output reg         resetTooShort
);
    localparam [3:0] ST_POWERUP = 4'h1;
    localparam [3:0] ST_HOLD    = 4'h2;
    localparam [3:0] ST_RUN     = 4'h4;
    localparam [3:0] ST_IDLE    = 4'h8;

    localparam [`PSC_HOLD_CNT_W-1:0] HOLD_LIMIT =
        RESET_HOLD_CYCLES[`PSC_HOLD_CNT_W-1:0];

    wire [`PSC_SYNC_W-1:0] rawPins;
    wire [`PSC_SYNC_W-1:0] pins;

    reg  [3:0]                  state;
    reg  [3:0]                  next_state;
    reg  [`PSC_STRAP_W-1:0]     latched;
    reg  [`PSC_HOLD_CNT_W-1:0]  holdCount;
    reg                         captureNow;

    wire        hwResetActive;
    wire        pinPowerDown;
    wire [1:0]  sdNeg;
    wire [1:0]  sdPos;
    wire [4:0]  strapAddr;

    reg  [1:0]  next_ifaceMode;
    reg  [1:0]  next_mediaMode;
    reg         next_speed;
    reg         next_duplex;
    reg  [3:0]  next_adv;
    reg  [15:0] next_ctrl;
    reg  [15:0] next_advWord;
    reg  [15:0] next_rxMode;

    assign rawPins = {signal_detect_pos,
                      signal_detect_neg,
                      power_down_pin_n,
                      hw_reset_n,
                      mgmt_addr_strap_bit4,
                      mgmt_addr_strap_bit3,
                      mgmt_addr_strap_bit2,
                      mgmt_addr_strap_bit1,
                      mgmt_addr_strap_bit0,
                      capability_strap_b,
                      capability_strap_a,
                      negotiation_enable_strap,
                      iface_mode_strap_b,
                      iface_mode_strap_a,
                      loopback_strap};

    // Every pin arrives from the board, so all of them pass two flops.
    psc_sync2 #(
        .WIDTH     (`PSC_SYNC_W),
        .RESET_VAL (`PSC_SYNC_DEFAULT)
    ) u_pinSync (
        .core_clk (core_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .pinIn    (rawPins),
        .syncOut  (pins)
    );

    assign hwResetActive = ~pins[`PSC_BIT_HWRSTN];
    assign pinPowerDown  = ~pins[`PSC_BIT_PWRDNN];
    assign sdNeg         = pins[`PSC_SDN_MSB:`PSC_SDN_LSB];
    assign sdPos         = pins[`PSC_SDP_MSB:`PSC_SDP_LSB];
    assign strapAddr     = latched[`PSC_ADDR_MSB:`PSC_ADDR_LSB];

    // Power-up (rst) and the reset pin both lead to a capture on the release
    // edge; the soft reset request is deliberately not an input of this FSM.
    always @* begin
        next_state = state;
        captureNow = 1'h0;
        case (state)
            ST_POWERUP: begin
                if (!hwResetActive) begin
                    captureNow = 1'h1;
                    next_state = ST_RUN;
                end else begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!hwResetActive) begin
                    captureNow = 1'h1;
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (hwResetActive) begin
                    next_state = ST_HOLD;
                end
            end
            default: begin
                next_state = ST_POWERUP;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (rst) begin
            state <= ST_POWERUP;
        end else if (clkEn) begin
            state <= next_state;
        end
    end

    // The strap image changes only at a capture; soft reset and the
    // power-down pin leave it untouched.
    always @(posedge core_clk) begin
        if (rst) begin
            latched <= `PSC_STRAP_DEFAULT;
        end else if (clkEn && captureNow) begin
            latched <= pins[`PSC_STRAP_W-1:0];
        end
    end

    // A pulse on the reset pin shorter than the required hold still captures,
    // but the shortfall is reported so a bring-up problem is visible.
    always @(posedge core_clk) begin
        if (rst) begin
            holdCount     <= {`PSC_HOLD_CNT_W{1'h0}};
            resetTooShort <= 1'h0;
        end else if (clkEn) begin
            if (state == ST_HOLD && hwResetActive) begin
                if (holdCount != HOLD_LIMIT) begin
                    holdCount <= holdCount + 1'h1;
                end
            end else begin
                holdCount <= {`PSC_HOLD_CNT_W{1'h0}};
            end
            if (state == ST_HOLD && captureNow) begin
                resetTooShort <= (holdCount < HOLD_LIMIT);
            end
        end
    end

    // Interface mode decode.
    always @* begin
        if (!latched[`PSC_BIT_CFGA]) begin
            next_ifaceMode = `PSC_IFACE_MII;
        end else if (!latched[`PSC_BIT_CFGB]) begin
            next_ifaceMode = `PSC_IFACE_RMII;
        end else begin
            next_ifaceMode = `PSC_IFACE_RSVD;
        end
    end

    // Speed, duplex and abilities from the negotiation and capability pair.
    // Bit order of next_adv is {100F, 100H, 10F, 10H}.
    always @* begin
        next_speed  = 1'h1;
        next_duplex = 1'h1;
        next_adv    = 4'hf;
        if (!latched[`PSC_BIT_ANEN]) begin
            next_speed  = latched[`PSC_BIT_CAPA];
            next_duplex = latched[`PSC_BIT_CAPB];
            case ({latched[`PSC_BIT_CAPA], latched[`PSC_BIT_CAPB]})
                2'h0:    next_adv = 4'h1;
                2'h1:    next_adv = 4'h2;
                2'h2:    next_adv = 4'h4;
                default: next_adv = 4'h8;
            endcase
        end else begin
            case ({latched[`PSC_BIT_CAPA], latched[`PSC_BIT_CAPB]})
                2'h0:    next_adv = 4'h3;
                2'h1:    next_adv = 4'hc;
                2'h2:    next_adv = 4'h5;
                default: next_adv = 4'hf;
            endcase
        end
    end

    // Media selection from the signal-detect pair; levels outside the
    // defined table give the undefined media code PSC_MEDIA_UNDEF.
    always @* begin
        if (sdNeg == `PSC_LVL_GND && sdPos == `PSC_LVL_GND) begin
            next_mediaMode = `PSC_MEDIA_TX;
        end else if ((sdNeg == `PSC_LVL_PLOW || sdNeg == `PSC_LVL_PMID)
                     && sdPos == `PSC_LVL_PHIGH) begin
            next_mediaMode = `PSC_MEDIA_FX_LINK;
        end else if (sdNeg != `PSC_LVL_GND && sdPos == `PSC_LVL_PLOW) begin
            next_mediaMode = `PSC_MEDIA_FX_IDLE;
        end else begin
            next_mediaMode = `PSC_MEDIA_UNDEF;
        end
    end

    // Register seeds that the management port logic loads at reset.
    always @* begin
        next_ctrl = 16'h0000;
        next_ctrl[`PSC_CTRL_LOOP]    = latched[`PSC_BIT_LOOP];
        next_ctrl[`PSC_CTRL_SPEED]   = next_speed;
        next_ctrl[`PSC_CTRL_ANEN]    = latched[`PSC_BIT_ANEN];
        next_ctrl[`PSC_CTRL_ISOLATE] = (strapAddr == `PSC_ADDR_ZERO);
        next_ctrl[`PSC_CTRL_DUPLEX]  = next_duplex;

        next_advWord = {11'h000, `PSC_ADV_SELECTOR};
        next_advWord[`PSC_ADV_10H]  = next_adv[0];
        next_advWord[`PSC_ADV_10F]  = next_adv[1];
        next_advWord[`PSC_ADV_100H] = next_adv[2];
        next_advWord[`PSC_ADV_100F] = next_adv[3];

        next_rxMode = 16'h0000;
        next_rxMode[`PSC_RXMODE_ADDR_LSB +: 5] = strapAddr;
    end

    // Decoded strap outputs follow the latched image, which only moves at a
    // capture, so they stay constant between hardware resets; powerDown and
    // dataPathIsolated also follow the power-down pin.
    always @(posedge core_clk) begin
        if (rst) begin
            configLoaded        <= 1'h0;
            inHwReset           <= 1'h1;
            ifaceMode           <= `PSC_IFACE_MII;
            mediaMode           <= `PSC_MEDIA_TX;
            negotiationEnable   <= 1'h1;
            forcedSpeed100      <= 1'h1;
            forcedFullDuplex    <= 1'h1;
            advertisedAbilities <= 4'hf;
            loopbackEnable      <= 1'h0;
            isolate             <= 1'h0;
            powerDown           <= 1'h0;
            dataPathIsolated    <= 1'h0;
            mgmtAddr            <= `PSC_ADDR_ONE;
            mgmtAddrMatch       <= 1'h0;
            controlSeed         <= 16'h3100;
            advertSeed          <= 16'h01e1;
            rxModeSeed          <= 16'h0001;
            rxModeIndex         <= `PSC_RXMODE_INDEX;
        end else if (clkEn) begin
            configLoaded        <= (state == ST_RUN);
            inHwReset           <= (state != ST_RUN);
            ifaceMode           <= next_ifaceMode;
            if (captureNow) begin
                mediaMode       <= next_mediaMode;
            end
            negotiationEnable   <= latched[`PSC_BIT_ANEN];
            forcedSpeed100      <= next_speed;
            forcedFullDuplex    <= next_duplex;
            advertisedAbilities <= next_adv;
            loopbackEnable      <= latched[`PSC_BIT_LOOP];
            isolate             <= (strapAddr == `PSC_ADDR_ZERO);
            powerDown           <= pinPowerDown;
            dataPathIsolated    <= (strapAddr == `PSC_ADDR_ZERO)
                                   | pinPowerDown;
            mgmtAddr            <= strapAddr;
            // Only management frames are matched against the address; data paths see it only through the zero-address isolate.
            mgmtAddrMatch       <= (mgmtFrameAddr == mgmtAddr);
            controlSeed         <= next_ctrl;
            advertSeed          <= next_advWord;
            rxModeSeed          <= next_rxMode;
            rxModeIndex         <= `PSC_RXMODE_INDEX;
        end
    end

    // The soft reset request is accepted as a port so the strap image can be
    // seen not to depend on it; it drives nothing here by design.
    wire unusedSoftReset = softResetReq;
endmodule

// >>> shared/psc_consts.vh
// Constants for the hardware-reset strap configuration loader.
// What this block does
// - Sample every strap at hardware reset; power-up latches the synchroniser default image; straps select modes.
// - Software reset or power-down pin never resamples; latched straps stay.
// - Interface mode: first bit low MII, high/low RMII, both high reserved.
// - Unconnected interface-mode straps read 0, so the device starts in MII.
// - Negotiation strap low forces speed and duplex from the capability pair.
// - Forced pair: 00 10M half, 01 10M full, 10 100M half, 11 100M full.
// - Negotiating pair: 00 10M, 01 100M, 10 both half, 11 all four.
// - Negotiation and capability straps default high, so 111 advertises all.
// - Strapped negotiation and capability seed control and advertisement words.
// - Five address straps latch into receive mode register 0x14, match accesses.
// - Default address bit 0 high, bits 4 to 1 low, so address one.
// - Both detects grounded selects TX; PECL levels select FX with link state.
// - Management registers are reached only through the serial management port.
// - All-zero address straps start with the data interface isolated.
`ifndef PSC_CONSTS_VH
`define PSC_CONSTS_VH

`define PSC_STRAP_W        11
`define PSC_BIT_LOOP       0
`define PSC_BIT_CFGA       1
`define PSC_BIT_CFGB       2
`define PSC_BIT_ANEN       3
`define PSC_BIT_CAPA       4
`define PSC_BIT_CAPB       5
`define PSC_ADDR_LSB       6
`define PSC_ADDR_MSB       10
`define PSC_STRAP_DEFAULT  11'h078

`define PSC_SYNC_W         17
`define PSC_BIT_HWRSTN     11
`define PSC_BIT_PWRDNN     12
`define PSC_SDN_LSB        13
`define PSC_SDN_MSB        14
`define PSC_SDP_LSB        15
`define PSC_SDP_MSB        16
`define PSC_SYNC_DEFAULT   17'h01878

`define PSC_LVL_GND        2'h0
`define PSC_LVL_PLOW       2'h1
`define PSC_LVL_PMID       2'h2
`define PSC_LVL_PHIGH      2'h3

`define PSC_IFACE_MII      2'h0
`define PSC_IFACE_RMII     2'h1
`define PSC_IFACE_RSVD     2'h2

`define PSC_MEDIA_TX       2'h0
`define PSC_MEDIA_FX_IDLE  2'h1
`define PSC_MEDIA_FX_LINK  2'h2
`define PSC_MEDIA_UNDEF    2'h3

`define PSC_CTRL_LOOP      14
`define PSC_CTRL_SPEED     13
`define PSC_CTRL_ANEN      12
`define PSC_CTRL_ISOLATE   10
`define PSC_CTRL_DUPLEX    8
`define PSC_ADV_10H        5
`define PSC_ADV_10F        6
`define PSC_ADV_100H       7
`define PSC_ADV_100F       8
`define PSC_ADV_SELECTOR   5'h01
`define PSC_RXMODE_INDEX   5'h14
`define PSC_RXMODE_ADDR_LSB 0

`define PSC_ADDR_ONE       5'h01
`define PSC_ADDR_ZERO      5'h00

`define PSC_CLK_PERIOD_NS  10
`define PSC_RESET_HOLD_NS  1000000
`define PSC_RESET_HOLD_CYCLES \
    ((`PSC_RESET_HOLD_NS + `PSC_CLK_PERIOD_NS - 1) / `PSC_CLK_PERIOD_NS)
`define PSC_HOLD_CNT_W     17

`endif

// >>> src/psc_sync2.v
// Two-stage synchroniser for a vector of pin levels.
`timescale 1ns/1ns
module psc_sync2 #(
    parameter WIDTH                  = 1,
    parameter [WIDTH-1:0] RESET_VAL  = {WIDTH{1'h0}}
) (
    input  wire             core_clk,
    input  wire             rst,
    input  wire             clkEn,
    input  wire [WIDTH-1:0] pinIn,
    output reg  [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1;

    // Only the second stage reads the first; nothing else may look at it.
    always @(posedge core_clk) begin
        if (rst) begin
            stage1  <= RESET_VAL;
            syncOut <= RESET_VAL;
        end else if (clkEn) begin
            stage1  <= pinIn;
            syncOut <= stage1;
        end
    end
endmodule

// >>> dv/psc_board_model.sv
// Board strap resistors and the hardware reset source.
`timescale 1ns/1ns
`include "psc_consts.vh"
module psc_board #(
    parameter HOLD = 25
) (
    input  wire        core_clk,
    input  wire [1:0]  req,
    input  wire [10:0] strapVal,
    input  wire [10:0] strapMask,
    output wire [10:0] strapPins,
    output reg         hw_reset_n = 1'b0
);
    integer cnt = HOLD;
    // A strap left floating settles to its weak internal pull.
    assign strapPins = (strapVal & strapMask) |
                       (`PSC_STRAP_DEFAULT & ~strapMask);
    // Request 1 is a full-length pulse, request 2 one that is too short.
    always @(posedge core_clk) begin
        if (req == 2'h1)
            cnt <= HOLD;
        else if (req == 2'h2)
            cnt <= 3;
        else if (cnt != 0)
            cnt <= cnt - 1;
        hw_reset_n <= (cnt <= 1) && (req == 2'h0);
    end
endmodule

// >>> dv/psc_strap_loader_assertions.sv
// Concurrent checks on the strap loader outputs.
`timescale 1ns/1ns
module psc_strap_checks (
    input wire        core_clk,
    input wire        rst,
    input wire        clkEn,
    input wire [4:0]  mgmtFrameAddr,
    input wire        configLoaded,
    input wire [1:0]  ifaceMode,
    input wire [1:0]  mediaMode,
    input wire        negotiationEnable,
    input wire        forcedSpeed100,
    input wire        forcedFullDuplex,
    input wire [3:0]  advertisedAbilities,
    input wire        loopbackEnable,
    input wire        isolate,
    input wire [4:0]  mgmtAddr,
    input wire        mgmtAddrMatch,
    input wire [15:0] controlSeed,
    input wire [15:0] advertSeed,
    input wire [15:0] rxModeSeed,
    input wire [4:0]  rxModeIndex
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    held_config_a: assert property (
        configLoaded && $past(configLoaded) |-> $stable(controlSeed) &&
        $stable(advertSeed) && $stable(ifaceMode) && $stable(mediaMode))
        else $error("latched config moved while loaded");
    ctrl_seed_a: assert property (
        controlSeed[14] == loopbackEnable && controlSeed[13] == forcedSpeed100
        && controlSeed[12] == negotiationEnable && controlSeed[10] == isolate
        && controlSeed[8] == forcedFullDuplex)
        else $error("control seed disagrees with decode");
    adv_seed_a: assert property (
        advertSeed == {7'h00, advertisedAbilities, 5'h01})
        else $error("advert seed disagrees with abilities");
    rx_seed_a: assert property (
        rxModeSeed == {11'h000, mgmtAddr} && rxModeIndex == 5'h14)
        else $error("rx mode seed wrong");
    isolate_addr_a: assert property (
        isolate == (mgmtAddr == 5'h00))
        else $error("isolate does not follow zero address");
    iface_code_a: assert property (ifaceMode != 2'h3)
        else $error("interface mode out of range");
    forced_one_a: assert property (
        !negotiationEnable |-> advertisedAbilities ==
        (4'h1 << {forcedSpeed100, forcedFullDuplex}))
        else $error("forced mode ability wrong");
    neg_adv_a: assert property (
        negotiationEnable |-> forcedSpeed100 && forcedFullDuplex &&
        advertisedAbilities inside {4'h3, 4'hc, 4'h5, 4'hf})
        else $error("negotiated abilities wrong");
    addr_match_a: assert property (
        $past(clkEn) && !$past(rst) |->
        mgmtAddrMatch == ($past(mgmtFrameAddr) == $past(mgmtAddr)))
        else $error("address match wrong");
    cover property ($rose(configLoaded));
    cover property (configLoaded && !negotiationEnable);
    cover property (configLoaded && isolate);
    cover property (mgmtAddrMatch);
endmodule
bind psc_strap_loader psc_strap_checks u_chk (.core_clk, .rst, .clkEn,
    .mgmtFrameAddr, .configLoaded, .ifaceMode, .mediaMode, .negotiationEnable,
    .forcedSpeed100, .forcedFullDuplex, .advertisedAbilities, .loopbackEnable,
    .isolate, .mgmtAddr, .mgmtAddrMatch, .controlSeed, .advertSeed,
    .rxModeSeed, .rxModeIndex);

// >>> dv/psc_strap_loader_test.sv
// Self-checking bench for the strap loader with a board model.
`timescale 1ns/1ns
module psc_strap_loader_test;
    logic core_clk, rst, clkEn, power_down_pin_n, softResetReq;
    logic [1:0] signal_detect_neg, signal_detect_pos, req;
    logic [4:0] mgmtFrameAddr;
    logic [10:0] strapVal, strapMask;
    wire [10:0] strapPins;
    wire hw_reset_n, configLoaded, inHwReset, negotiationEnable;
    wire forcedSpeed100, forcedFullDuplex, loopbackEnable, isolate;
    wire powerDown, dataPathIsolated, mgmtAddrMatch, resetTooShort;
    wire [1:0] ifaceMode, mediaMode;
    wire [3:0] advertisedAbilities;
    wire [4:0] mgmtAddr, rxModeIndex;
    wire [15:0] controlSeed, advertSeed, rxModeSeed;
    int j, err_total, comparisons;
    logic [24:0] r;
    logic [24:0] rows [9];

    psc_board BRD (.core_clk, .req, .strapVal, .strapMask, .strapPins,
        .hw_reset_n);
    psc_strap_loader #(.RESET_HOLD_CYCLES(20)) DUT (.core_clk, .rst,
        .clkEn, .hw_reset_n, .power_down_pin_n, .softResetReq,
        .loopback_strap(strapPins[0]), .iface_mode_strap_a(strapPins[1]),
        .iface_mode_strap_b(strapPins[2]),
        .negotiation_enable_strap(strapPins[3]),
        .capability_strap_a(strapPins[4]), .capability_strap_b(strapPins[5]),
        .mgmt_addr_strap_bit0(strapPins[6]), .mgmt_addr_strap_bit1(strapPins[7]),
        .mgmt_addr_strap_bit2(strapPins[8]), .mgmt_addr_strap_bit3(strapPins[9]),
        .mgmt_addr_strap_bit4(strapPins[10]), .signal_detect_neg,
        .signal_detect_pos, .mgmtFrameAddr, .configLoaded, .inHwReset,
        .ifaceMode, .mediaMode, .negotiationEnable, .forcedSpeed100,
        .forcedFullDuplex, .advertisedAbilities, .loopbackEnable, .isolate,
        .powerDown, .dataPathIsolated, .mgmtAddr, .mgmtAddrMatch, .controlSeed,
        .advertSeed, .rxModeSeed, .rxModeIndex, .resetTooShort);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task results;
        $display("Mismatches %0d in %0d comparisons", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task tick;
        @(posedge core_clk);
        #1;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Kind 0 only waits, 1 pulses a full reset, 2 a short one.
    task load(input logic [10:0] v, input logic [10:0] m,
              input logic [1:0] n, input logic [1:0] p, input logic [1:0] k);
        int i;
        @(posedge core_clk);
        strapVal <= v;
        strapMask <= m;
        signal_detect_neg <= n;
        signal_detect_pos <= p;
        req <= k;
        @(posedge core_clk);
        req <= 2'h0;
        // Look only once the edge has settled, never in its own time step.
        tick();
        for (i = 0; i < 99 && inHwReset !== 1'b1; i++)
            tick();
        if (inHwReset !== 1'b1) begin
            chk(inHwReset, 1'b1);
            results();
        end
        for (i = 0; i < 99 && configLoaded !== 1'b1; i++)
            tick();
        if (configLoaded !== 1'b1) begin
            chk(configLoaded, 1'b1);
            results();
        end
    endtask

    initial begin
        rows[0] = {11'h040, 2'h0, 2'h0, 2'h0, 2'h0, 4'h1, 2'h0};
        rows[1] = {11'h064, 2'h1, 2'h1, 2'h0, 2'h1, 4'h2, 2'h1};
        rows[2] = {11'h052, 2'h2, 2'h3, 2'h1, 2'h2, 4'h4, 2'h2};
        rows[3] = {11'h076, 2'h0, 2'h3, 2'h2, 2'h3, 4'h8, 2'h3};
        rows[4] = {11'h048, 2'h3, 2'h1, 2'h0, 2'h1, 4'h3, 2'h3};
        rows[5] = {11'h069, 2'h3, 2'h3, 2'h0, 2'h3, 4'hc, 2'h3};
        rows[6] = {11'h058, 2'h1, 2'h3, 2'h0, 2'h2, 4'h5, 2'h3};
        rows[7] = {11'h7f8, 2'h0, 2'h0, 2'h0, 2'h0, 4'hf, 2'h3};
        rows[8] = {11'h038, 2'h0, 2'h0, 2'h0, 2'h0, 4'hf, 2'h3};
        rst = 1'b1;
        clkEn = 1'b1;
        power_down_pin_n = 1'b1;
        softResetReq = 1'b0;
        signal_detect_neg = 2'h0;
        signal_detect_pos = 2'h0;
        mgmtFrameAddr = 5'h00;
        strapVal = 11'h7ff;
        strapMask = 11'h000;
        req = 2'h0;
        repeat (3) @(posedge core_clk);
        #1;
        chk(controlSeed, 16'h3100);
        chk(configLoaded, 1'b0);
        @(posedge core_clk);
        rst <= 1'b0;
        // Power-up capture with every strap left floating.
        load(11'h7ff, 11'h000, 2'h0, 2'h0, 2'h0);
        chk(controlSeed, 16'h3100);
        chk(advertSeed, 16'h01e1);
        chk(rxModeSeed, 16'h0001);
        chk(ifaceMode, 2'h0);
        for (j = 0; j < 9; j++) begin
            r = rows[j];
            load(r[24:14], 11'h7ff, r[13:12], r[11:10], 2'h1);
            chk(ifaceMode, r[9:8]);
            chk(mediaMode, r[7:6]);
            chk(advertisedAbilities, r[5:2]);
            chk({forcedSpeed100, forcedFullDuplex}, r[1:0]);
            chk(negotiationEnable, r[17]);
            chk(loopbackEnable, r[14]);
            chk(mgmtAddr, r[24:20]);
            chk(isolate, r[24:20] == 5'h00);
            chk(resetTooShort, 1'b0);
            @(posedge core_clk);
            mgmtFrameAddr <= r[24:20];
            tick();
            chk(mgmtAddrMatch, 1'b1);
            @(posedge core_clk);
            mgmtFrameAddr <= r[24:20] + 5'h01;
            tick();
            chk(mgmtAddrMatch, 1'b0);
        end
        // Soft reset and the power pin must leave the latched straps alone.
        @(posedge core_clk);
        strapVal <= 11'h000;
        softResetReq <= 1'b1;
        power_down_pin_n <= 1'b0;
        repeat (4) tick();
        chk(powerDown, 1'b1);
        chk(dataPathIsolated, 1'b1);
        chk(controlSeed, 16'h3500);
        @(posedge core_clk);
        softResetReq <= 1'b0;
        power_down_pin_n <= 1'b1;
        clkEn <= 1'b0;
        repeat (3) tick();
        chk(powerDown, 1'b1);
        @(posedge core_clk);
        clkEn <= 1'b1;
        repeat (4) tick();
        chk(powerDown, 1'b0);
        chk(mgmtAddr, 5'h00);
        // A pulse below the hold time still recaptures but is flagged.
        load(11'h040, 11'h7ff, 2'h0, 2'h0, 2'h2);
        chk(resetTooShort, 1'b1);
        chk(controlSeed, 16'h0000);
        results();
    end
endmodule
